// ### design/pps_ctrl_top.sv
// Host controller driving the phase splitter pins under AXI4-Lite control
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "pps_defines.svh"
module pps_ctrl_top
  import pps_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pwm_input_line_i,
  output logic pwm_input_line_o,
  output logic pwm_input_line_oe,
  output logic [1:0] mode_enable_select,
  output logic stage2_enable_hold,
  input wire logic load_step_i
);
  pps_pwm_if pif ();

  logic [5:0] ctrl_q; // Software control bits
  logic [15:0] period_q; // Wanted per-phase period, clocks
  logic [15:0] width_q; // Wanted line pulse width, clocks
  pps_mode_t mode_q; // Band now driven on the enable pin
  logic line_m_q, line_s_q; // Line readback synchroniser
  logic step_m_q, step_s_q; // Load-step synchroniser
  logic stage2_q, pwm_o_q, pwm_oe_q;
  logic clamp; // Width was cut to keep duty legal
  logic boost; // Load step forcing synchronous band
  logic interleave;
  logic [15:0] ctl_period, ctl_width, shifted;
  pps_mode_t want_mode;
  logic wr_go, rd_go;
  logic [31:0] wmask, rd_word;
  logic rd_hit;

  // Pin inputs cross into ref_clk through two flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_m_q <= 1'b0;
      line_s_q <= 1'b0;
      step_m_q <= 1'b0;
      step_s_q <= 1'b0;
    end else begin
      line_m_q <= pwm_input_line_i;
      line_s_q <= line_m_q;
      step_m_q <= load_step_i;
      step_s_q <= step_m_q;
    end
  end

  // Band selection from control, load step and the line-high ban
  always_comb begin
    boost = ctrl_q[`PPS_CTRL_BOOST] && step_s_q; // R17
    if (!ctrl_q[`PPS_CTRL_RUN]) begin
      want_mode = PPS_MODE_OFF;
    end else if (boost) begin
      want_mode = PPS_MODE_SYNC; // R17
    end else begin
      want_mode = pps_mode_t'(ctrl_q[`PPS_CTRL_MODE_HI:`PPS_CTRL_MODE_LO]);
    end
    // Grounding the pin would make the splitter pull the line high
    if (ctrl_q[`PPS_CTRL_FORBID] && want_mode == PPS_MODE_OFF) begin
      want_mode = PPS_MODE_IL1; // R16
    end
  end

  // Controller rate scaled to the mode; duty capped in interleave
  always_comb begin
    interleave = (mode_q == PPS_MODE_IL1) || (mode_q == PPS_MODE_IL2);
    if (!interleave) begin
      shifted = period_q; // R13
    end else if (ctrl_q[`PPS_CTRL_CASCADE]) begin
      shifted = period_q >> 2; // R14
    end else begin
      shifted = period_q >> 1; // R12
    end
    ctl_period = (shifted == 16'h0000) ? 16'h0001 : shifted;
    // Under one controller period keeps each phase below its share
    clamp = interleave && (width_q >= ctl_period);
    ctl_width = clamp ? ctl_period - 16'h0001 : width_q; // R12 R14
  end

  assign pif.run = (mode_q != PPS_MODE_OFF);
  assign pif.period = ctl_period;
  assign pif.width = ctl_width;

  pps_pwm_gen u_gen (
    .ref_clk(ref_clk),
    .rst(rst),
    .pif(pif)
  );

  // Pin drive; the line is released while the splitter is off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= PPS_MODE_OFF;
      pwm_o_q <= 1'b0;
      pwm_oe_q <= 1'b0;
      stage2_q <= 1'b1;
    end else begin
      mode_q <= want_mode;
      pwm_o_q <= pif.pwm;
      pwm_oe_q <= (mode_q != PPS_MODE_OFF); // R2
      stage2_q <= 1'b1; // R15
    end
  end

  assign pwm_input_line_o = pwm_o_q;
  assign pwm_input_line_oe = pwm_oe_q;
  assign mode_enable_select = mode_q;
  assign stage2_enable_hold = stage2_q;

  // Write taken only with address and data both present
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                 && !s_axi_awready;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // Register writes honour byte strobes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `PPS_CTRL_RST;
      period_q <= `PPS_PERIOD_RST;
      width_q <= `PPS_WIDTH_RST;
    end else if (wr_go) begin
      unique case (s_axi_awaddr)
        `PPS_CTRL_OFS: ctrl_q <= (ctrl_q & ~wmask[5:0])
                                 | (s_axi_wdata[5:0] & wmask[5:0]);
        `PPS_PERIOD_OFS: period_q <= (period_q & ~wmask[15:0])
                                     | (s_axi_wdata[15:0] & wmask[15:0]);
        `PPS_WIDTH_OFS: width_q <= (width_q & ~wmask[15:0])
                                   | (s_axi_wdata[15:0] & wmask[15:0]);
        default: ;
      endcase
    end
  end

  // Write handshake and response; unmapped gives SLVERR
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PPS_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      // Response code fixed at take, shown only after the handshake
      if (wr_go) begin
        s_axi_bresp <= (s_axi_awaddr <= `PPS_STATUS_OFS
                        && s_axi_awaddr[1:0] == 2'h0)
                       ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
      end
      // Valid follows the accepted address and data; set wins
      if (s_axi_awready && s_axi_wready) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; status shows pin and limiter state
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h00000000;
    unique case (s_axi_araddr)
      `PPS_CTRL_OFS: rd_word[5:0] = ctrl_q;
      `PPS_PERIOD_OFS: rd_word[15:0] = period_q;
      `PPS_WIDTH_OFS: rd_word[15:0] = width_q;
      `PPS_STATUS_OFS: rd_word[4:0] = {boost, clamp, mode_q, line_s_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read handshake
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PPS_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      // Word captured at take; it stands until the data handshake
      if (rd_go) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
      end
      // Data shown once the address handshake is done; set wins
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  il_half_rate_a: assert property ( // R12
    (interleave && !ctrl_q[`PPS_CTRL_CASCADE] && period_q > 16'h0001)
      |-> pif.period == (period_q >> 1))
    else $error("interleave period not half of phase period");
  sync_full_rate_a: assert property ( // R13
    (mode_q == PPS_MODE_SYNC && period_q != 16'h0000)
      |-> pif.period == period_q && pif.width == width_q)
    else $error("sync mode rate or width altered");
  cascade_quarter_a: assert property ( // R14
    (interleave && ctrl_q[`PPS_CTRL_CASCADE] && period_q > 16'h0003)
      |-> pif.period == (period_q >> 2))
    else $error("cascade period not quarter");
  duty_cap_a: assert property ( // R12
    interleave |-> pif.width < pif.period)
    else $error("interleave pulse too wide");
  stage2_high_a: assert property ( // R15
    stage2_enable_hold)
    else $error("second stage enable dropped");
  forbid_keep_a: assert property ( // R16
    ctrl_q[`PPS_CTRL_FORBID] |=> mode_enable_select != PPS_MODE_OFF)
    else $error("enable grounded while line-high forbidden");
  boost_sync_a: assert property ( // R17
    (ctrl_q[`PPS_CTRL_BOOST] && step_s_q && ctrl_q[`PPS_CTRL_RUN])
      |=> mode_enable_select == PPS_MODE_SYNC)
    else $error("load step did not force sync band");
  line_release_a: assert property ( // R2
    $fell(pif.run) |=> !pwm_input_line_oe)
    else $error("line still driven after disable");
  wr_resp_a: assert property (
    wr_go |-> ##1 (s_axi_awready && s_axi_wready) ##1 s_axi_bvalid)
    else $error("write not answered in order");
endmodule

// ### design/pps_defines.svh
// Offsets, field positions, reset values and codes of the splitter controller
// Overview of operation
// R1: Ground-level enable stops splitting, outputs suspended
// R2: Disabled splitter pulls the PWM line high
// R3: Re-enable releases line, splitting resumes on rise
// R4: Outputs tri-stated until first rise, except overvoltage
// R5: Overvoltage above 60% of monitor full scale
// R6: Disabled at or below 0.8V, enabled above 2V
// R7: Top band selects first interleave, 70ns extension
// R8: 78-85% band selects second interleave, 120ns extension
// R9: Second interleave needs band held four cycles
// R10: 54-64% band selects synchronous mode
// R11: Interleave routes pulses alternately to both phases
// R12: Interleave: twice phase rate, duty under half
// R13: Synchronous: phase rate, duty up to full
// R14: Cascade: four times rate, duty under quarter
// R15: Cascaded second stage enable held high
// R16: Keep enable high where line-high is forbidden
// R17: Load step may force synchronous band briefly
// R18: Long tri-state input drives outputs mid-level
// R19: Rise turns phase on, fall turns off
// R20: Levels between bands keep previous mode
// R21: External comparators decode enable level bands
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH
// Register byte offsets
`define PPS_CTRL_OFS 8'h00
`define PPS_PERIOD_OFS 8'h04
`define PPS_WIDTH_OFS 8'h08
`define PPS_STATUS_OFS 8'h0C
// Control fields
`define PPS_CTRL_RUN 0
`define PPS_CTRL_MODE_LO 1
`define PPS_CTRL_MODE_HI 2
`define PPS_CTRL_CASCADE 3
`define PPS_CTRL_FORBID 4
`define PPS_CTRL_BOOST 5
// Status fields
`define PPS_STAT_LINE 0
`define PPS_STAT_MODE_LO 1
`define PPS_STAT_MODE_HI 2
`define PPS_STAT_CLAMP 3
`define PPS_STAT_BOOST 4
// Reset values
`define PPS_CTRL_RST 6'h00
`define PPS_PERIOD_RST 16'h0064
`define PPS_WIDTH_RST 16'h0010
// AXI responses
`define PPS_RESP_OKAY 2'h0
`define PPS_RESP_SLVERR 2'h2
`endif

// ### design/pps_pkg.sv
// Types shared by the splitter controller modules
package pps_pkg;
  // Enable-pin band codes driven to the level network
  typedef enum logic [1:0] {
    PPS_MODE_OFF = 2'b00,
    PPS_MODE_SYNC = 2'b01,
    PPS_MODE_IL2 = 2'b10,
    PPS_MODE_IL1 = 2'b11
  } pps_mode_t;
endpackage

// ### design/pps_pwm_gen.sv
// Period and width counter that makes the controller PWM line
`timescale 1ns/100ps
module pps_pwm_gen (
  input wire logic ref_clk,
  input wire logic rst,
  pps_pwm_if.gen pif
);
  logic [15:0] cnt_q; // Position in the current period
  logic pwm_q; // Line level
  logic wrap_q; // Start-of-period pulse
  logic last; // Final count of the period

  assign last = (cnt_q >= pif.period - 16'h0001);
  assign pif.pwm = pwm_q;
  assign pif.wrap = wrap_q;

  // Counter; period shrinking mid-cycle wraps at once
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else if (!pif.run || last) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Level is high for the first width counts; full width gives 100%
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwm_q <= 1'b0;
    end else if (!pif.run) begin
      pwm_q <= 1'b0;
    end else if (last) begin
      pwm_q <= (pif.width != 16'h0000); // R13
    end else begin
      pwm_q <= ((cnt_q + 16'h0001) < pif.width);
    end
  end

  // One-cycle marker at each period start
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrap_q <= 1'b0;
    end else begin
      wrap_q <= pif.run && last;
    end
  end
endmodule

// ### design/pps_pwm_if.sv
// Link between controller register side and PWM generator
`timescale 1ns/100ps
interface pps_pwm_if;
  logic run;
  logic [15:0] period;
  logic [15:0] width;
  logic pwm;
  logic wrap;
  modport ctl (output run, output period, output width, input pwm,
               input wrap);
  modport gen (input run, input period, input width, output pwm,
               output wrap);
endinterface

// ### dv/pps_split_model.sv
// Behavioural phase splitter facing the controller pins
`timescale 1ns/100ps
module pps_split_model
  import pps_pkg::*;
#(
  parameter int HOLDOFF = 8 // Released cycles before mid-level outputs
)
(
  input wire logic ref_clk,
  input wire logic o,
  input wire logic oe,
  input wire logic [1:0] mode,
  input wire logic ovp,
  output logic line,
  output logic pa,
  output logic pb,
  output logic hiz
);
  logic prev = 1'b0; // Line seen last cycle
  logic sel = 1'b0; // Phase for next pulse
  logic arm = 1'b0; // Set by first rise
  logic mid; // Released too long, outputs at mid-level
  pps_mode_t eff = PPS_MODE_OFF; // Mode the splitter acts in
  logic [1:0] qual = 2'h0; // Rises counted in the second band
  int rel = 0; // Cycles left released while enabled
  // Off band pulls the line high; a released line reads inverted
  assign line = oe ? o : (mode == PPS_MODE_OFF ? 1'b1 : ~o);
  // Arm on rise; swap phase on fall so a pulse never splits
  always_ff @(posedge ref_clk) begin
    prev <= line;
    if (mode == PPS_MODE_OFF) begin
      arm <= 1'b0;
    end else begin
      if (line && !prev) arm <= 1'b1;
      if (!line && prev) sel <= ~sel;
    end
  end
  // Band decode; the second band must hold four rises first
  always_ff @(posedge ref_clk) begin
    if (mode == PPS_MODE_OFF) begin
      eff <= PPS_MODE_OFF;
      qual <= 2'h0;
    end else if (mode != PPS_MODE_IL2) begin
      eff <= pps_mode_t'(mode);
      qual <= 2'h0;
    end else if (line && !prev) begin
      // Short of four rises the old mode stands
      if (qual == 2'h3) begin
        eff <= PPS_MODE_IL2;
      end else begin
        qual <= qual + 2'h1;
      end
    end
  end
  // Holdoff count while the line is left released
  always_ff @(posedge ref_clk) begin
    if (oe || mode == PPS_MODE_OFF) begin
      rel <= 0;
    end else if (rel < HOLDOFF) begin
      rel <= rel + 1;
    end
  end
  assign mid = (rel >= HOLDOFF);
  // Both phases in sync, alternate otherwise
  assign pa = arm && !mid && line
              && (eff == PPS_MODE_SYNC || sel);
  assign pb = arm && !mid && line
              && (eff == PPS_MODE_SYNC || !sel);
  // Overvoltage lifts the hold; a long release forces mid-level
  assign hiz = mid || (!arm && !ovp);
endmodule

// ### dv/tb_top.sv
// Bench for the splitter controller over AXI4-Lite
`timescale 1ns/100ps
`include "pps_defines.svh"
module tb_top
  import pps_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, ls = 0;
  logic [3:0] ws = 4'hF; // Write strobes
  logic ov = 1'b0; // Overvoltage seen by the splitter
  logic awr, wry, bv, arr, rv, po, poe, s2, line, pa, pb, hiz;
  logic [1:0] br, rr, msel;
  logic [31:0] rdat, rd;
  logic pq = 0, aq = 0, bq = 0; // Edge detect history
  int err_total = 0, check_count = 0, na = 0, nb = 0, nl = 0, i;
  pps_mode_t mc [3] = '{PPS_MODE_SYNC, PPS_MODE_IL2, PPS_MODE_IL1};
  int mp [3] = '{20, 10, 10}; // Line period per mode
  always #5 ref_clk = ~ref_clk;
  pps_ctrl_top i_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .s_axi_awaddr(awa),
    .s_axi_awvalid(awv),
    .s_axi_awready(awr),
    .s_axi_wdata(wd),
    .s_axi_wstrb(ws),
    .s_axi_wvalid(wv),
    .s_axi_wready(wry),
    .s_axi_bresp(br),
    .s_axi_bvalid(bv),
    .s_axi_bready(bry),
    .s_axi_araddr(ara),
    .s_axi_arvalid(arv),
    .s_axi_arready(arr),
    .s_axi_rdata(rdat),
    .s_axi_rresp(rr),
    .s_axi_rvalid(rv),
    .s_axi_rready(rry),
    .pwm_input_line_i(line),
    .pwm_input_line_o(po),
    .pwm_input_line_oe(poe),
    .mode_enable_select(msel),
    .stage2_enable_hold(s2),
    .load_step_i(ls)
  );
  pps_split_model i_split (
    .ref_clk(ref_clk),
    .o(po),
    .oe(poe),
    .mode(msel),
    .ovp(ov),
    .line(line),
    .pa(pa),
    .pb(pb),
    .hiz(hiz)
  );
  // Rising edges of line and both phases
  always @(posedge ref_clk) begin
    pq <= line;
    aq <= pa;
    bq <= pb;
    if (line && !pq) nl++;
    if (pa && !aq) na++;
    if (pb && !bq) nb++;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Wait ran out: count it and stop
  task hang;
    err_total++;
    results;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Write; address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic got;
    got = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (n = 0; n < 50 && !got; n++) begin
      @(posedge ref_clk);
      if (awr) awv <= 1'b0;
      if (wry) wv <= 1'b0;
      if (bv) begin
        got = 1;
        bry <= 1'b0;
        chk(32'(br), 32'(e));
      end
    end
    // One edge passes so the next call never re-raises bready at once
    if (!got) hang;
    else @(posedge ref_clk);
  endtask
  // Read into rd and compare the response
  task rdc(input logic [7:0] a, input logic [1:0] e);
    int n;
    logic got;
    got = 0;
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (n = 0; n < 50 && !got; n++) begin
      @(posedge ref_clk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        got = 1;
        rry <= 1'b0;
        rd = rdat;
        chk(32'(rr), 32'(e));
      end
    end
    // One edge passes so the next call never re-raises rready at once
    if (!got) hang;
    else @(posedge ref_clk);
  endtask
  // Edges until the driven line shows v
  task wlev(input logic v, output int c);
    c = 0;
    while (po !== v) begin
      @(posedge ref_clk);
      c++;
      if (c > 300) hang;
    end
  endtask
  task meas(input int per, input int wid);
    int t, hi, lo;
    wlev(0, t);
    wlev(1, t);
    wlev(0, hi);
    wlev(1, lo);
    chk(32'(hi), 32'(wid));
    chk(32'(hi + lo), 32'(per));
  endtask
  // Four whole pulses, counted per phase
  task phs(input logic sync);
    int a0, b0, l0, t;
    wlev(0, t);
    a0 = na;
    b0 = nb;
    l0 = nl;
    repeat (4) begin
      wlev(1, t);
      wlev(0, t);
    end
    chk(32'(na - a0), sync ? 32'(nl - l0) : 32'h2);
    chk(32'(nb - b0), sync ? 32'(nl - l0) : 32'h2);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    cyc(1);
    chk(32'(msel), 32'h0);
    chk(32'(s2), 32'h1);
    rdc(`PPS_CTRL_OFS, 2'h0);
    chk(32'(rd[5:0]), 32'h0);
    rdc(`PPS_PERIOD_OFS, 2'h0);
    chk(32'(rd[15:0]), 32'h64);
    rdc(`PPS_WIDTH_OFS, 2'h0);
    chk(32'(rd[15:0]), 32'h10);
    wr(8'h10, 32'h1, 2'h2);
    rdc(8'h02, 2'h2);
    wr(`PPS_STATUS_OFS, 32'h1F, 2'h0);
    rdc(`PPS_STATUS_OFS, 2'h0);
    chk(32'(rd[0]), 32'h1);
    // Low byte only: the upper period byte keeps its reset value
    ws <= 4'h1;
    wr(`PPS_PERIOD_OFS, 32'h0000AA33, 2'h0);
    ws <= 4'hF;
    rdc(`PPS_PERIOD_OFS, 2'h0);
    chk(32'(rd[15:0]), 32'h33);
    wr(`PPS_PERIOD_OFS, 32'h14, 2'h0);
    wr(`PPS_WIDTH_OFS, 32'h5, 2'h0);
    for (i = 0; i < 3; i++) begin
      wr(`PPS_CTRL_OFS, 32'({mc[i], 1'b1}), 2'h0);
      cyc(3);
      chk(32'(msel), 32'(mc[i]));
      chk(32'(poe), 32'h1);
      // Second band needs four rises before it routes alternately
      repeat (2) meas(mp[i], 5);
      phs(i == 0);
      chk(32'(hiz), 32'h0);
    end
    // Cascade: quarter period, width clamped
    wr(`PPS_CTRL_OFS, 32'hF, 2'h0);
    cyc(3);
    meas(5, 4);
    rdc(`PPS_STATUS_OFS, 2'h0);
    chk(32'(rd[3]), 32'h1);
    wr(`PPS_CTRL_OFS, 32'h11, 2'h0);
    cyc(3);
    chk(32'(msel), 32'h3);
    wr(`PPS_CTRL_OFS, 32'h27, 2'h0);
    ls <= 1'b1;
    cyc(6);
    chk(32'(msel), 32'h1);
    ls <= 1'b0;
    cyc(6);
    chk(32'(msel), 32'h3);
    wr(`PPS_CTRL_OFS, 32'h1, 2'h0);
    cyc(6);
    chk(32'(msel), 32'h0);
    chk(32'(poe), 32'h0);
    chk(32'(hiz), 32'h1);
    ov <= 1'b1;
    cyc(2);
    chk(32'(hiz), 32'h0);
    results;
  end
endmodule
